// *** bsfs_pkg.sv ***
// Purpose: constants for the boost startup and fault supervisor
// Assumes: analog levels arrive as comparator outputs
// Notes:   clk 100 MHz; switching cycle marked by a pwm_tick pulse
//
// Summary of operation
// - no switching while driver supply under lockout
// - supply loss: power good low, gates low, discharge
// - bias enabled with enable level one and supply
// - init reads config pin, soft-start held discharged
// - after init charge soft-start to target
// - switch once soft-start above floor, feedback below
// - overvoltage armed only above soft-start arm level
// - enable below upper falling level: shutdown, discharge
// - enable below lower falling level: bias off
// - peak limit during low side ends low side
// - per-phase peak counter over limit trips fault
// - overcurrent fault waits fixed cycles then retries
// - fast overcurrent on two cycles trips fault
// - below negative limit keep low side on
// - per-phase negative counter over limit trips fault
// - config pin enables or disables overvoltage
// - overvoltage declared after 129 qualified cycles
// - overvoltage: power good low, discharge, drivers off
// - overvoltage restarts at once when cleared
// - overvoltage disabled: power good while feedback above reference
// - config pin selects level shifter and phase count
// - thermal fault disables until hysteresis cools
package bsfs_pkg;

  localparam int          NUM_PHASES    = 2;
  localparam int          EVT_CNT_W     = 6;
  localparam logic [5:0]  EVT_LIMIT     = 6'h20;    // trip when count exceeds 32
  localparam int          RETRY_W       = 16;
  localparam int          RETRY_CYCLES  = 32768;    // wait in switching cycles
  localparam int          OV_CNT_W      = 8;
  localparam logic [7:0]  OV_LIMIT      = 8'h80;    // trip when above 128 cycles
  localparam int          FAST_CNT_W    = 2;
  localparam logic [1:0]  FAST_LIMIT    = 2'h2;
  localparam int          INIT_CYCLES   = 16;       // config pin sampling window
  localparam int          INIT_CNT_W    = 5;
  localparam int          CFG_W         = 3;

  // config code bit positions after decode
  localparam int          CFG_OV_EN_BIT = 0;
  localparam int          CFG_SHIFT_BIT = 1;
  localparam int          CFG_SINGLE_BIT = 2;

  typedef enum logic [2:0] {
    BSFS_OFF      = 3'b000,
    BSFS_BIAS     = 3'b001,
    BSFS_INIT     = 3'b010,
    BSFS_SOFT     = 3'b011,
    BSFS_RUN      = 3'b100,
    BSFS_RETRY    = 3'b101,
    BSFS_OV_HOLD  = 3'b110,
    BSFS_THERM    = 3'b111
  } bsfs_state_t;

endpackage : bsfs_pkg

// *** bsfs_supervisor.sv ***
// Purpose: startup sequencing and fault supervision of a boost controller
// Assumes: all inputs are asynchronous comparator levels
// Notes:   pwm_tick_in is a switching clock level from the oscillator; its rising edge marks a cycle
`timescale 1ns/1ps
module bsfs_supervisor #(
  parameter int RETRY_WAIT = bsfs_pkg::RETRY_CYCLES,
  parameter int PHASES     = bsfs_pkg::NUM_PHASES
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              pwm_tick_in,
  input  wire logic              driver_supply_input,
  input  wire logic              enable_lockout_input,
  input  wire logic              enable_low_falling,
  input  wire logic              enable_high_rising,
  input  wire logic              enable_high_falling,
  input  wire logic              reference_stable,
  input  wire logic [bsfs_pkg::CFG_W-1:0] overvoltage_config_pin,
  input  wire logic              soft_start_at_target,
  input  wire logic              soft_start_above_floor,
  input  wire logic              soft_start_above_arm,
  input  wire logic              feedback_below_soft_start,
  input  wire logic              feedback_over_trip,
  input  wire logic              feedback_above_reference,
  input  wire logic              thermal_hot,
  input  wire logic              thermal_cooled,
  input  wire logic [PHASES-1:0] pwm_end_in,
  input  wire logic [PHASES-1:0] peak_current_limit,
  input  wire logic [PHASES-1:0] fast_overcurrent_trip,
  input  wire logic [PHASES-1:0] negative_current_limit,
  output logic                   bias_enable,
  output logic                   soft_start_discharge,
  output logic                   soft_start_charge,
  output logic                   power_good_out,
  output logic [PHASES-1:0]      low_side_gate_out,
  output logic [PHASES-1:0]      high_side_gate_out,
  output logic                   level_shift_enable,
  output logic                   single_phase_mode,
  output logic                   fault_active
);
  import bsfs_pkg::*;

  localparam int NIN = 14 + 4 * PHASES;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;

  assign raw_in = {pwm_tick_in, driver_supply_input, enable_lockout_input,
                   enable_low_falling, enable_high_rising, enable_high_falling,
                   reference_stable, soft_start_at_target, soft_start_above_floor,
                   soft_start_above_arm, feedback_below_soft_start,
                   feedback_over_trip, feedback_above_reference, thermal_hot,
                   pwm_end_in, peak_current_limit, fast_overcurrent_trip,
                   negative_current_limit};

  logic [CFG_W-1:0] cfg_s1;
  logic [CFG_W-1:0] cfg_s2;
  logic             cool_s1;
  logic             cool_s2;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1   <= '0;
      sync2   <= '0;
      cfg_s1  <= '0;
      cfg_s2  <= '0;
      cool_s1 <= 1'b0;
      cool_s2 <= 1'b0;
    end else begin
      sync1   <= raw_in;
      sync2   <= sync1;
      cfg_s1  <= overvoltage_config_pin;
      cfg_s2  <= cfg_s1;
      cool_s1 <= thermal_cooled;
      cool_s2 <= cool_s1;
    end
  end

  logic              tick_lvl;
  logic              drv_ok;
  logic              en_low_r;
  logic              en_low_f;
  logic              en_high_r;
  logic              en_high_f;
  logic              ref_ok;
  logic              ss_target;
  logic              ss_floor;
  logic              ss_arm;
  logic              fb_below_ss;
  logic              fb_over;
  logic              fb_above_ref;
  logic              hot;
  logic [PHASES-1:0] pend;
  logic [PHASES-1:0] peak;
  logic [PHASES-1:0] fast;
  logic [PHASES-1:0] neg;

  assign {tick_lvl, drv_ok, en_low_r, en_low_f, en_high_r, en_high_f, ref_ok,
          ss_target, ss_floor, ss_arm, fb_below_ss, fb_over, fb_above_ref, hot,
          pend, peak, fast, neg} = sync2;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bsfs_state_t                 st;
    logic                        tick_d;
    logic                        bias;
    logic                        ss_dis;
    logic                        ss_chg;
    logic                        pg;
    logic [PHASES-1:0]           dl;
    logic [PHASES-1:0]           dh;
    logic [PHASES-1:0]           neg_hold;
    logic [PHASES-1:0]           limited;
    logic [CFG_W-1:0]            cfg;
    logic [INIT_CNT_W-1:0]       init_cnt;
    logic [RETRY_W:0]            retry_cnt;
    logic [OV_CNT_W:0]           ov_cnt;
    logic [PHASES*EVT_CNT_W-1:0] peak_cnt;
    logic [PHASES*EVT_CNT_W-1:0] neg_cnt;
    logic [PHASES*FAST_CNT_W-1:0] fast_cnt;
    logic                        fault;
  } bsfs_regs_t;

  bsfs_regs_t r;
  bsfs_regs_t next_r;

  // config decode: ov enable, level shifter, single phase
  function automatic logic [2:0] bsfs_decode(input logic [CFG_W-1:0] code);
    case (code)
      3'h0:    bsfs_decode = 3'b001;
      3'h1:    bsfs_decode = 3'b010;
      3'h2:    bsfs_decode = 3'b011;
      3'h3:    bsfs_decode = 3'b000;
      3'h4:    bsfs_decode = 3'b110;
      3'h5:    bsfs_decode = 3'b111;
      3'h6:    bsfs_decode = 3'b100;
      default: bsfs_decode = 3'b101;
    endcase
  endfunction : bsfs_decode

  logic [2:0] cfg_dec;
  logic       tick;
  logic       oc_trip;
  logic       go_off;
  logic [EVT_CNT_W-1:0]  pc;
  logic [EVT_CNT_W-1:0]  nc;
  logic [FAST_CNT_W-1:0] fc;

  assign cfg_dec = r.cfg;
  assign tick    = tick_lvl & ~r.tick_d;

  always_comb begin
    next_r        = r;
    next_r.tick_d = tick_lvl;
    oc_trip       = 1'b0;
    pc            = '0;
    nc            = '0;
    fc            = '0;

    // bias regulator staging
    if (drv_ok && en_low_r)
      next_r.bias = 1'b1;
    else if (!drv_ok || !en_low_f)
      next_r.bias = 1'b0;

    // per-phase event counting and cycle control
    for (int p = 0; p < PHASES; p++) begin
      pc = r.peak_cnt[p*EVT_CNT_W +: EVT_CNT_W];
      nc = r.neg_cnt[p*EVT_CNT_W +: EVT_CNT_W];
      fc = r.fast_cnt[p*FAST_CNT_W +: FAST_CNT_W];
      if (r.st == BSFS_RUN) begin
        if (tick) begin
          if (peak[p])
            pc = pc + 1'b1;
          else if (pc != '0)
            pc = pc - 1'b1;
          if (neg[p])
            nc = nc + 1'b1;
          else if (nc != '0)
            nc = nc - 1'b1;
          if (fast[p])
            fc = fc + 1'b1;
          else
            fc = '0;
          next_r.limited[p]  = 1'b0;
          next_r.neg_hold[p] = 1'b0;
          next_r.dl[p]       = 1'b1;
          next_r.dh[p]       = 1'b0;
          if (single_phase_mode && p != 0)
            next_r.dl[p] = 1'b0;
        end else if (r.dl[p]) begin
          if (neg[p]) begin
            next_r.neg_hold[p] = 1'b1;
          end else if (peak[p] || fast[p]) begin
            next_r.dl[p]      = 1'b0;
            next_r.dh[p]      = 1'b1;
            next_r.limited[p] = 1'b1;
          end else if (pend[p] && !r.neg_hold[p]) begin
            next_r.dl[p] = 1'b0;
            next_r.dh[p] = 1'b1;
          end else if (pend[p] && r.neg_hold[p] && !neg[p]) begin
            next_r.dl[p]       = 1'b0;
            next_r.dh[p]       = 1'b1;
            next_r.neg_hold[p] = 1'b0;
          end
        end

        // idle phase in single mode ignores its comparators
        if (cfg_dec[CFG_SINGLE_BIT] && p != 0) begin
          pc = '0;
          nc = '0;
          fc = '0;
        end
        if (pc > EVT_LIMIT || nc > EVT_LIMIT)
          oc_trip = 1'b1;
        if (fc >= FAST_LIMIT)
          oc_trip = 1'b1;
      end
      next_r.peak_cnt[p*EVT_CNT_W +: EVT_CNT_W]    = pc;
      next_r.neg_cnt[p*EVT_CNT_W +: EVT_CNT_W]     = nc;
      next_r.fast_cnt[p*FAST_CNT_W +: FAST_CNT_W]  = fc;
    end

    go_off = !drv_ok || !en_high_f || !r.bias;

    case (r.st)
      BSFS_OFF: begin
        if (r.bias && en_high_r && ref_ok) begin
          next_r.st       = BSFS_INIT;
          next_r.init_cnt = '0;
        end
      end
      BSFS_BIAS: next_r.st = BSFS_OFF;
      BSFS_INIT: begin
        // keep the decoded setting so outputs need no logic
        next_r.cfg      = bsfs_decode(cfg_s2);
        next_r.init_cnt = r.init_cnt + 1'b1;
        if (r.init_cnt == INIT_CNT_W'(INIT_CYCLES - 1))
          next_r.st = BSFS_SOFT;
      end
      BSFS_SOFT: begin
        if (ss_floor && fb_below_ss && drv_ok)
          next_r.st = BSFS_RUN;
      end
      BSFS_RUN: begin
        if (hot) begin
          next_r.st = BSFS_THERM;
        end else if (r.ov_cnt > {1'b0, OV_LIMIT}) begin
          next_r.st = BSFS_OV_HOLD;
        end else if (oc_trip) begin
          next_r.st        = BSFS_RETRY;
          next_r.retry_cnt = '0;
        end
      end
      BSFS_RETRY: begin
        if (tick)
          next_r.retry_cnt = r.retry_cnt + 1'b1;
        if (r.retry_cnt >= (RETRY_W + 1)'(RETRY_WAIT))
          next_r.st = BSFS_SOFT;
      end
      BSFS_OV_HOLD: begin
        if (!fb_over)
          next_r.st = BSFS_SOFT;
      end
      BSFS_THERM: begin
        if (cool_s2 && !hot)
          next_r.st = BSFS_SOFT;
      end
      default: next_r.st = BSFS_OFF;
    endcase

    // thermal fault also stops a soft-start in progress
    if (hot && (r.st == BSFS_SOFT || r.st == BSFS_RUN))
      next_r.st = BSFS_THERM;

    if (go_off && r.st != BSFS_OFF)
      next_r.st = BSFS_OFF;

    // outputs follow the next state
    next_r.fault  = (next_r.st == BSFS_RETRY) || (next_r.st == BSFS_OV_HOLD) ||
                    (next_r.st == BSFS_THERM);
    next_r.ss_dis = (next_r.st != BSFS_SOFT) && (next_r.st != BSFS_RUN);
    next_r.ss_chg = !next_r.ss_dis && !ss_target;

    if (next_r.st != BSFS_RUN) begin
      next_r.dl       = '0;
      next_r.dh       = '0;
      next_r.neg_hold = '0;
      next_r.limited  = '0;
    end
    if (next_r.st != BSFS_RUN || r.st != BSFS_RUN) begin
      next_r.peak_cnt = '0;
      next_r.neg_cnt  = '0;
      next_r.fast_cnt = '0;
    end

    // overvoltage qualification in switching cycles
    if (next_r.ss_dis || !cfg_dec[CFG_OV_EN_BIT] || !ss_arm || r.st != BSFS_RUN) begin
      next_r.ov_cnt = '0;
    end else if (fb_over) begin
      if (tick && r.ov_cnt <= {1'b0, OV_LIMIT})
        next_r.ov_cnt = r.ov_cnt + 1'b1;
    end else begin
      next_r.ov_cnt = '0;
    end

    // power good
    if (next_r.ss_dis)
      next_r.pg = 1'b0;
    else if (!cfg_dec[CFG_OV_EN_BIT])
      next_r.pg = fb_above_ref;
    else
      next_r.pg = (next_r.st == BSFS_RUN) && !fb_over && ss_arm;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r        <= '0;
      r.st     <= BSFS_OFF;
      r.ss_dis <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bias_enable          = r.bias;
  assign soft_start_discharge = r.ss_dis;
  assign soft_start_charge    = r.ss_chg;
  assign power_good_out       = r.pg;
  assign low_side_gate_out    = r.dl;
  assign high_side_gate_out   = r.dh;
  // config bits come straight from the decoded register
  assign level_shift_enable   = cfg_dec[CFG_SHIFT_BIT];
  assign single_phase_mode    = cfg_dec[CFG_SINGLE_BIT];
  assign fault_active         = r.fault;

endmodule : bsfs_supervisor

// *** bsfs_chk.sv ***
// Purpose: concurrent checks on the supervisor ports
// Assumes: outputs trail comparator inputs by three clocks
// Notes:   bound into every supervisor instance
`timescale 1ns/1ps
module bsfs_chk #(
  parameter int PHASES = 2
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              driver_supply_input,
  input wire logic              enable_low_falling,
  input wire logic              enable_high_falling,
  input wire logic              bias_enable,
  input wire logic              soft_start_discharge,
  input wire logic              soft_start_charge,
  input wire logic              power_good_out,
  input wire logic [PHASES-1:0] low_side_gate_out,
  input wire logic [PHASES-1:0] high_side_gate_out,
  input wire logic              fault_active
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_supply_gates;
    !driver_supply_input [*4] |=> low_side_gate_out == '0 && high_side_gate_out == '0;
  endproperty
  a_supply_gates: assert property (p_supply_gates) else $error("gates on without supply");
  property p_supply_pg;
    !driver_supply_input [*4] |=> !power_good_out && soft_start_discharge;
  endproperty
  a_supply_pg: assert property (p_supply_pg) else $error("no discharge on supply loss");
  property p_bias_off;
    (!enable_low_falling || !driver_supply_input) [*4] |=> !bias_enable;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias on while enable low");
  property p_shutdown;
    !enable_high_falling [*4] |=> soft_start_discharge && low_side_gate_out == '0;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("switching after enable fell");
  property p_no_overlap;
    (low_side_gate_out & high_side_gate_out) == '0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates of a phase on");
  property p_dis_gates;
    soft_start_discharge |-> low_side_gate_out == '0 && high_side_gate_out == '0;
  endproperty
  a_dis_gates: assert property (p_dis_gates) else $error("gates on while discharging");
  property p_dis_pg;
    soft_start_discharge |-> !power_good_out;
  endproperty
  a_dis_pg: assert property (p_dis_pg) else $error("power good while discharging");
  property p_init_hold;
    $rose(bias_enable) |-> soft_start_discharge [*8];
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("init window too short");
  property p_charge_after;
    $fell(soft_start_discharge) |-> soft_start_charge;
  endproperty
  a_charge_after: assert property (p_charge_after) else $error("no charge after release");
  property p_retry_hold;
    $rose(fault_active) |-> fault_active [*8];
  endproperty
  a_retry_hold: assert property (p_retry_hold) else $error("retry wait cut short");
  c_run: cover property ($rose(low_side_gate_out[0]));
  c_fault: cover property ($rose(fault_active));
  c_pg: cover property ($rose(power_good_out));
endmodule : bsfs_chk

bind bsfs_supervisor bsfs_chk #(.PHASES(PHASES)) u_bsfs_chk (
  .clk, .rstn, .driver_supply_input, .enable_low_falling, .enable_high_falling,
  .bias_enable, .soft_start_discharge, .soft_start_charge, .power_good_out,
  .low_side_gate_out, .high_side_gate_out, .fault_active
);

// *** bsfs_far_model.sv ***
// Purpose: oscillator and soft-start node seen by the supervisor
// Assumes: node ramps one step a clock while charged
// Notes:   tick is a square wave, high for half a period
`timescale 1ns/1ps
module bsfs_far_model #(
  parameter int TICK   = 8,
  parameter int SS_TOP = 40
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic soft_start_charge,
  input  wire logic soft_start_discharge,
  output logic      pwm_tick_in,
  output logic      soft_start_above_floor,
  output logic      soft_start_above_arm,
  output logic      soft_start_at_target
);
  int div;
  int lvl;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div <= 0;
      lvl <= 0;
    end else begin
      div <= (div == TICK - 1) ? 0 : div + 1;
      if (soft_start_discharge)
        lvl <= 0;
      else if (soft_start_charge && lvl < SS_TOP)
        lvl <= lvl + 1;
    end
  end
  assign pwm_tick_in            = div < TICK / 2;
  assign soft_start_above_floor = lvl > 1;
  assign soft_start_above_arm   = lvl > SS_TOP / 2;
  assign soft_start_at_target   = lvl >= SS_TOP;
endmodule : bsfs_far_model

// *** testbench.sv ***
// Purpose: directed tests of startup, faults and config decode
// Assumes: retry wait shortened to 4 ticks, tick every 8 clocks
// Notes:   inputs change on the falling clock edge
`timescale 1ns/1ps
module testbench;
  import bsfs_pkg::*;
  localparam logic [7:0] SHIFT_MAP = 8'h36;
  localparam logic [7:0] OV_MAP    = 8'hA5;
  logic clk = 0, rstn = 0, pwm_tick_in, driver_supply_input = 0, enable_lockout_input = 0;
  logic enable_low_falling = 0, enable_high_rising = 0, enable_high_falling = 0;
  logic reference_stable = 1, feedback_below_soft_start = 1, feedback_over_trip = 0;
  logic feedback_above_reference = 1, thermal_hot = 0, thermal_cooled = 1;
  logic soft_start_at_target, soft_start_above_floor, soft_start_above_arm;
  logic [2:0] overvoltage_config_pin = '0;
  logic [1:0] pwm_end_in = '0, peak_current_limit = '0;
  logic [1:0] fast_overcurrent_trip = '0, negative_current_limit = '0;
  logic bias_enable, soft_start_discharge, soft_start_charge, power_good_out;
  logic level_shift_enable, single_phase_mode, fault_active;
  logic [1:0] low_side_gate_out, high_side_gate_out;
  int mismatches = 0;
  int compares = 0;
  int t;

  bsfs_supervisor #(.RETRY_WAIT(4)) uut (
    .clk                       (clk),
    .rstn                      (rstn),
    .pwm_tick_in               (pwm_tick_in),
    .driver_supply_input       (driver_supply_input),
    .enable_lockout_input      (enable_lockout_input),
    .enable_low_falling        (enable_low_falling),
    .enable_high_rising        (enable_high_rising),
    .enable_high_falling       (enable_high_falling),
    .reference_stable          (reference_stable),
    .overvoltage_config_pin    (overvoltage_config_pin),
    .soft_start_at_target      (soft_start_at_target),
    .soft_start_above_floor    (soft_start_above_floor),
    .soft_start_above_arm      (soft_start_above_arm),
    .feedback_below_soft_start (feedback_below_soft_start),
    .feedback_over_trip        (feedback_over_trip),
    .feedback_above_reference  (feedback_above_reference),
    .thermal_hot               (thermal_hot),
    .thermal_cooled            (thermal_cooled),
    .pwm_end_in                (pwm_end_in),
    .peak_current_limit        (peak_current_limit),
    .fast_overcurrent_trip     (fast_overcurrent_trip),
    .negative_current_limit    (negative_current_limit),
    .bias_enable               (bias_enable),
    .soft_start_discharge      (soft_start_discharge),
    .soft_start_charge         (soft_start_charge),
    .power_good_out            (power_good_out),
    .low_side_gate_out         (low_side_gate_out),
    .high_side_gate_out        (high_side_gate_out),
    .level_shift_enable        (level_shift_enable),
    .single_phase_mode         (single_phase_mode),
    .fault_active              (fault_active)
  );
  bsfs_far_model u_far (
    .clk                    (clk),
    .rstn                   (rstn),
    .soft_start_charge      (soft_start_charge),
    .soft_start_discharge   (soft_start_discharge),
    .pwm_tick_in            (pwm_tick_in),
    .soft_start_above_floor (soft_start_above_floor),
    .soft_start_above_arm   (soft_start_above_arm),
    .soft_start_at_target   (soft_start_at_target)
  );

  always #5 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk

  task automatic clks(int n);
    repeat (n) @(negedge clk);
  endtask : clks

  task automatic align();
    @(posedge pwm_tick_in);
    @(negedge clk);
  endtask : align

  task automatic wait_fault();
    t = 0;
    while (fault_active !== 1'b1 && t < 400) begin
      clks(1);
      t++;
    end
  endtask : wait_fault

  task automatic start(logic [2:0] code);
    rstn = 0;
    {enable_lockout_input, enable_low_falling, enable_high_rising, enable_high_falling} = '0;
    {driver_supply_input, feedback_over_trip, thermal_hot} = '0;
    {pwm_end_in, peak_current_limit, fast_overcurrent_trip, negative_current_limit} = '0;
    overvoltage_config_pin = code;
    clks(6);
    rstn = 1;
    clks(2);
    driver_supply_input = 1; // enable raised only after supply is up
    clks(4);
    {enable_lockout_input, enable_low_falling, enable_high_rising, enable_high_falling} = '1;
    t = 0;
    while (low_side_gate_out[0] !== 1'b1 && t < 300) begin
      clks(1);
      t++;
    end
    chk("switching", low_side_gate_out[0], 1);
    clks(40);
  endtask : start

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    for (int c = 0; c < 8; c++) begin
      start(3'(c));
      chk("shift", level_shift_enable, SHIFT_MAP[c]);
      chk("single", single_phase_mode, c >= 4);
      chk("pg_above_ref", power_good_out, 1);
      feedback_above_reference = 0;
      clks(5);
      chk("pg_below_ref", power_good_out, OV_MAP[c]);
      feedback_above_reference = 1;
    end
    $display("test config done");
    start(0);
    feedback_over_trip = 1;
    clks(960);
    chk("ov_early", soft_start_discharge, 0);
    clks(96);
    chk("ov_trip", soft_start_discharge, 1);
    chk("ov_pg", power_good_out, 0);
    feedback_over_trip = 0;
    clks(6);
    chk("ov_restart", soft_start_discharge, 0);
    chk("ov_charge", soft_start_charge, 1);
    $display("test overvoltage done");
    start(0);
    align();
    peak_current_limit[0] = 1;
    clks(6);
    chk("dl_cut", low_side_gate_out[0], 0);
    chk("dh_on", high_side_gate_out[0], 1);
    wait_fault();
    chk("oc_count", t >= 248 && t <= 270, 1);
    chk("oc_fault", fault_active, 1);
    chk("oc_gates", low_side_gate_out | high_side_gate_out, 0);
    peak_current_limit[0] = 0;
    clks(16);
    chk("retry_wait", soft_start_discharge, 1);
    clks(32);
    chk("retry_go", soft_start_discharge, 0);
    $display("test peak limit done");
    start(0);
    align();
    fast_overcurrent_trip[1] = 1;
    wait_fault();
    chk("fast_two", t > 8 && t <= 24, 1);
    chk("fast_fault", fault_active, 1);
    fast_overcurrent_trip[1] = 0;
    start(0);
    align();
    {negative_current_limit[0], pwm_end_in[0]} = 2'h3;
    clks(6);
    chk("neg_hold", low_side_gate_out[0], 1);
    wait_fault();
    chk("neg_count", t >= 248 && t <= 270, 1);
    $display("test fast and negative done");
    start(0);
    {thermal_hot, thermal_cooled} = 2'h2;
    clks(5);
    chk("hot", soft_start_discharge, 1);
    thermal_hot = 0;
    clks(5);
    chk("not_cooled", soft_start_discharge, 1);
    feedback_below_soft_start = 0;
    thermal_cooled = 1;
    clks(6);
    chk("cooled", soft_start_discharge, 0);
    clks(30);
    chk("fb_high_hold", low_side_gate_out[0], 0);
    feedback_below_soft_start = 1;
    clks(20);
    chk("fb_low_go", low_side_gate_out[0], 1);
    {enable_high_falling, enable_high_rising} = '0;
    clks(5);
    chk("en_dis", soft_start_discharge, 1);
    chk("bias_kept", bias_enable, 1);
    {enable_low_falling, enable_lockout_input} = '0;
    clks(5);
    chk("bias_off", bias_enable, 0);
    start(0);
    driver_supply_input = 0;
    clks(5);
    chk("uv_gates", low_side_gate_out | high_side_gate_out, 0);
    chk("uv_pg", power_good_out, 0);
    chk("uv_dis", soft_start_discharge, 1);
    $display("test shutdown done");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : testbench
